// [hw/sewc_eeprom.sv]
// Implementation choices: the input filter, the protection reset value and the programming time.
`include "sewc_defs.svh"

module sewc_eeprom (
  input  wire logic       clk_sys,       // system clock
  input  wire logic       rst,           // async reset, active high
  sewc_link_if.dev        link,          // serial link, device end
  output logic            prog_busy,     // programming cycle running
  output logic [1:0]      block_protect  // current protection level
);

  logic [3:0]  raw;
  logic [3:0]  s1_reg;
  logic [3:0]  s2_reg;
  logic [3:0]  s3_reg;
  logic [3:0]  filt_reg;
  logic [3:0]  prev_reg;
  logic        cs_f;
  logic        sck_f;
  logic        si_f;
  logic        wp_f;
  logic        sck_fall;
  logic        sck_rise;
  logic        cs_rise;

  sewc_pkg::sewc_dev_st_t st_reg;
  logic [2:0]  bit_cnt_reg;
  logic [6:0]  sh_reg;
  logic [8:0]  addr_reg;
  logic [1:0]  pg_ptr_reg;
  logic [3:0]  pg_valid_reg;
  logic [7:0]  page_buf [4];
  logic [1:0]  wst_bp_reg;
  logic [1:0]  bp_reg;
  logic        wel_reg;
  logic        busy_reg;
  logic [7:0]  busy_cnt_reg;
  logic [7:0]  out_sh_reg;
  logic [2:0]  out_cnt_reg;
  logic        so_reg;
  logic        so_oe_reg;
  logic [7:0]  mem [512];

  logic        byte_done;
  logic [7:0]  in_byte;
  logic [7:0]  stat_byte;
  logic        prog_go;
  logic        stat_go;
  logic        busy_end;
  logic [8:0]  addr_inc;

  function automatic logic is_protected(input logic [1:0] bp,
                                        input logic [8:0] a);
    logic p;
    p = 1'b0;
    unique case (bp)
      2'b00: p = 1'b0;
      2'b01: p = (a >= `SEWC_PROT_L1_BASE);
      2'b10: p = (a >= `SEWC_PROT_L2_BASE);
      2'b11: p = 1'b1;
    endcase
    return p;
  endfunction : is_protected

  // three-stage sampling; a level is taken once stages two and three agree
  assign raw = {link.wp_n, link.si, link.sck, link.cs_n};

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s1_reg   <= 4'hB;
      s2_reg   <= 4'hB;
      s3_reg   <= 4'hB;
      filt_reg <= 4'hB;
      prev_reg <= 4'hB;
    end else begin
      s1_reg   <= raw;
      s2_reg   <= s1_reg;
      s3_reg   <= s2_reg;
      filt_reg <= (s2_reg & s3_reg) | (filt_reg & (s2_reg | s3_reg));
      prev_reg <= filt_reg;
    end
  end

  assign cs_f     = filt_reg[0];
  assign sck_f    = filt_reg[1];
  assign si_f     = filt_reg[2];
  assign wp_f     = filt_reg[3];
  assign sck_fall = prev_reg[1] & ~sck_f & ~cs_f;            // [RULE18]
  assign sck_rise = ~prev_reg[1] & sck_f & ~cs_f;            // [RULE18]
  assign cs_rise  = ~prev_reg[0] & cs_f;

  assign byte_done = sck_fall && (bit_cnt_reg == 3'h7);
  assign in_byte   = {sh_reg, si_f};
  assign addr_inc  = addr_reg + 9'h001;
  assign busy_end  = busy_reg && (busy_cnt_reg == 8'h01);
  assign stat_byte = {4'h0, bp_reg, wel_reg, busy_reg};      // [RULE1] [RULE4]

  // writes are judged at deselect; a partial byte or a missing latch
  // drops the command with no trace
  assign prog_go = cs_rise && (st_reg == sewc_pkg::D_DATA)   // [RULE11]
                   && (bit_cnt_reg == 3'h0) && (pg_valid_reg != 4'h0)
                   && wel_reg && wp_f && !busy_reg;          // [RULE8] [RULE15]
  assign stat_go = cs_rise && (st_reg == sewc_pkg::D_WST_DONE)
                   && (bit_cnt_reg == 3'h0)
                   && wel_reg && wp_f && !busy_reg;          // [RULE19]

  // command sequencing
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_reg       <= sewc_pkg::D_OPC;
      bit_cnt_reg  <= 3'h0;
      sh_reg       <= 7'h00;
      addr_reg     <= 9'h000;
      pg_ptr_reg   <= 2'h0;
      pg_valid_reg <= 4'h0;
      wst_bp_reg   <= 2'h0;
    end else if (cs_f) begin
      st_reg       <= sewc_pkg::D_OPC;
      bit_cnt_reg  <= 3'h0;
      pg_valid_reg <= 4'h0;
    end else begin
      if (sck_fall) begin
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        sh_reg      <= {sh_reg[5:0], si_f};                  // [RULE18]
      end
      if (byte_done) begin
        unique case (st_reg)
          sewc_pkg::D_OPC: begin                             // [RULE17]
            if (in_byte == `SEWC_OP_RD_STAT)
              st_reg <= sewc_pkg::D_STOUT;                   // [RULE5]
            else if (busy_reg)
              st_reg <= sewc_pkg::D_SKIP;                    // [RULE12]
            else if (in_byte == `SEWC_OP_WR_STAT)
              st_reg <= sewc_pkg::D_WST;
            else if ((in_byte & `SEWC_OP_ARR_MASK) == `SEWC_OP_ARR_WR) begin
              addr_reg[8] <= in_byte[`SEWC_OP_ADDR_BIT];
              st_reg      <= sewc_pkg::D_ADDR;
            end else if ((in_byte & `SEWC_OP_ARR_MASK) == `SEWC_OP_ARR_RD)
            begin
              addr_reg[8] <= in_byte[`SEWC_OP_ADDR_BIT];
              st_reg      <= sewc_pkg::D_RADDR;
            end else
              st_reg <= sewc_pkg::D_SKIP;
          end
          sewc_pkg::D_ADDR: begin                            // [RULE10]
            addr_reg[7:0] <= in_byte;
            pg_ptr_reg    <= in_byte[1:0];
            st_reg        <= sewc_pkg::D_DATA;
          end
          sewc_pkg::D_DATA: begin                            // [RULE13]
            pg_valid_reg[pg_ptr_reg] <= 1'b1;
            pg_ptr_reg               <= pg_ptr_reg + 2'h1;
          end
          sewc_pkg::D_WST: begin
            wst_bp_reg <= in_byte[3:2];                      // [RULE16]
            st_reg     <= sewc_pkg::D_WST_DONE;
          end
          sewc_pkg::D_WST_DONE: st_reg <= sewc_pkg::D_SKIP;
          sewc_pkg::D_RADDR: begin
            addr_reg[7:0] <= in_byte;
            st_reg        <= sewc_pkg::D_RDOUT;
          end
          sewc_pkg::D_RDOUT, sewc_pkg::D_STOUT, sewc_pkg::D_SKIP:
            st_reg <= st_reg;
        endcase
      end
      if (sck_rise && (st_reg == sewc_pkg::D_RDOUT) && (out_cnt_reg == 3'h7))
        addr_reg <= addr_inc;
    end
  end

  // page bytes land at the wrapped pointer, so a fifth byte overwrites
  always_ff @(posedge clk_sys) begin
    if (byte_done && !cs_f && (st_reg == sewc_pkg::D_DATA))
      page_buf[pg_ptr_reg] <= in_byte;                       // [RULE13]
  end

  always_ff @(posedge clk_sys) begin
    if (prog_go) begin
      for (int i = 0; i < 4; i++) begin
        if (pg_valid_reg[i] &&
            !is_protected(bp_reg, {addr_reg[8:2], 2'(i)}))   // [RULE9]
          mem[{addr_reg[8:2], 2'(i)}] <= page_buf[i];        // [RULE8]
      end
    end
  end

  // protection level is nonvolatile in a real part; here it restarts
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst)
      bp_reg <= `SEWC_BP_RESET;
    else if (stat_go)
      bp_reg <= wst_bp_reg;                                  // [RULE16]
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst)
      wel_reg <= 1'b0;                                       // [RULE6]
    else if (busy_end)
      wel_reg <= 1'b0;                                       // [RULE14] [RULE20]
    else if (byte_done && !cs_f && (st_reg == sewc_pkg::D_OPC) &&
             !busy_reg) begin
      if (in_byte == `SEWC_OP_SET_WE)
        wel_reg <= 1'b1;                                     // [RULE2]
      else if (in_byte == `SEWC_OP_CLR_WE)
        wel_reg <= 1'b0;                                     // [RULE7]
    end
  end

  // the protect pin is only looked at when a cycle is launched, so a
  // cycle already running is never cut short
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      busy_reg     <= 1'b0;
      busy_cnt_reg <= 8'h00;
    end else if (prog_go || stat_go) begin
      busy_reg     <= 1'b1;                                  // [RULE3] [RULE11]
      busy_cnt_reg <= `SEWC_PROG_CYCLES;                     // [RULE20]
    end else if (busy_reg) begin
      busy_cnt_reg <= busy_cnt_reg - 8'h01;
      if (busy_end)
        busy_reg <= 1'b0;                                    // [RULE19]
    end
  end

  // output shifter; a held read keeps streaming, status reloaded live
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      out_sh_reg  <= 8'h00;
      out_cnt_reg <= 3'h0;
      so_reg      <= 1'b0;
      so_oe_reg   <= 1'b0;
    end else if (cs_f) begin
      out_cnt_reg <= 3'h0;
      so_oe_reg   <= 1'b0;
    end else if (byte_done && (st_reg == sewc_pkg::D_OPC) &&
                 (in_byte == `SEWC_OP_RD_STAT)) begin
      out_sh_reg  <= stat_byte;                              // [RULE5]
      out_cnt_reg <= 3'h0;
    end else if (byte_done && (st_reg == sewc_pkg::D_RADDR)) begin
      out_sh_reg  <= mem[{addr_reg[8], in_byte}];
      out_cnt_reg <= 3'h0;
    end else if (sck_rise && ((st_reg == sewc_pkg::D_STOUT) ||
                              (st_reg == sewc_pkg::D_RDOUT))) begin
      so_reg      <= out_sh_reg[7];                          // [RULE18]
      so_oe_reg   <= 1'b1;
      out_cnt_reg <= out_cnt_reg + 3'h1;
      if (out_cnt_reg != 3'h7)
        out_sh_reg <= {out_sh_reg[6:0], 1'b0};
      else if (st_reg == sewc_pkg::D_STOUT)
        out_sh_reg <= stat_byte;
      else
        out_sh_reg <= mem[addr_inc];
    end
  end

  assign link.so       = so_reg;
  assign link.so_oe    = so_oe_reg;
  assign prog_busy     = busy_reg;
  assign block_protect = bp_reg;

endmodule : sewc_eeprom

// [hw/sewc_master.sv]
`include "sewc_defs.svh"

module sewc_master (
  input  wire logic        clk_sys,  // system clock
  input  wire logic        rst,      // async reset, active high
  input  wire logic [7:0]  paddr,    // APB address
  input  wire logic        psel,     // APB select
  input  wire logic        penable,  // APB enable
  input  wire logic        pwrite,   // APB direction
  input  wire logic [31:0] pwdata,   // APB write data
  output logic      [31:0] prdata,   // APB read data
  output logic             pready,   // APB ready
  output logic             pslverr,  // APB error
  sewc_link_if.ctl         link      // serial link, master end
);

  localparam logic [7:0] HALF = 8'(`SEWC_SCK_HALF_CYC);

  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic [3:0]  cmd_reg;
  logic [31:0] txa_reg;
  logic [31:0] txb_reg;
  logic [7:0]  rxd_reg;
  logic        done_reg;
  logic [31:0] ctrl_reg;

  sewc_pkg::sewc_host_st_t st_reg;
  logic [7:0]  cnt_reg;
  logic [6:0]  bit_reg;
  logic [6:0]  total_reg;
  logic [6:0]  txbits_reg;
  logic [63:0] tx_sh_reg;
  logic        cs_n_reg;
  logic        sck_reg;
  logic        si_reg;
  logic [2:0]  miso_sh_reg;
  logic        miso_f_reg;

  logic        access;
  logic        wr_go;
  logic        start;
  logic        mapped;
  logic [31:0] rd_mux;

  assign access = psel && penable && pready_reg;
  assign wr_go  = access && pwrite;
  assign start  = wr_go && (paddr == `SEWC_REG_CMD) &&
                  (st_reg == sewc_pkg::H_IDLE) && (pwdata[2:0] != 3'h0);

  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      `SEWC_REG_CMD:  rd_mux = {28'h0, cmd_reg};
      `SEWC_REG_TXA:  rd_mux = txa_reg;
      `SEWC_REG_TXB:  rd_mux = txb_reg;
      `SEWC_REG_RXD:  rd_mux = {24'h0, rxd_reg};
      `SEWC_REG_STAT: rd_mux = {30'h0, done_reg,
                                st_reg != sewc_pkg::H_IDLE};
      `SEWC_REG_CTRL: rd_mux = ctrl_reg;
      default:        mapped = 1'b0;
    endcase
  end

  // no wait state: the answer is registered in the setup cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (psel && !penable && !pready_reg) begin
      pready_reg  <= 1'b1;
      prdata_reg  <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr_reg <= !mapped;
    end else begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cmd_reg  <= 4'h0;
      txa_reg  <= 32'h0000_0000;
      txb_reg  <= 32'h0000_0000;
      ctrl_reg <= `SEWC_CTRL_RESET;
    end else if (wr_go) begin
      if (paddr == `SEWC_REG_CMD && st_reg == sewc_pkg::H_IDLE)
        cmd_reg <= pwdata[3:0];
      if (paddr == `SEWC_REG_TXA)
        txa_reg <= pwdata;
      if (paddr == `SEWC_REG_TXB)
        txb_reg <= pwdata;
      if (paddr == `SEWC_REG_CTRL)
        ctrl_reg <= {31'h0, pwdata[0]};
    end
  end

  // finish wins over a same-cycle software clear
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst)
      done_reg <= 1'b0;
    else if (st_reg == sewc_pkg::H_TAIL && cnt_reg == 8'h00)
      done_reg <= 1'b1;
    else if (wr_go && paddr == `SEWC_REG_STAT &&
             pwdata[`SEWC_STAT_DONE_BIT])
      done_reg <= 1'b0;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      miso_sh_reg <= 3'h7;
      miso_f_reg  <= 1'b1;
    end else begin
      miso_sh_reg <= {miso_sh_reg[1:0], link.miso};
      if (miso_sh_reg[1] == miso_sh_reg[2])
        miso_f_reg <= miso_sh_reg[2];
    end
  end

  // clock idles high; data changes after rising, device samples falling
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_reg     <= sewc_pkg::H_IDLE;
      cnt_reg    <= 8'h00;
      bit_reg    <= 7'h00;
      total_reg  <= 7'h00;
      txbits_reg <= 7'h00;
      tx_sh_reg  <= 64'h0;
      rxd_reg    <= 8'h00;
      cs_n_reg   <= 1'b1;
      sck_reg    <= 1'b1;
      si_reg     <= 1'b0;
    end else begin
      if (cnt_reg != 8'h00)
        cnt_reg <= cnt_reg - 8'h01;
      unique case (st_reg)
        sewc_pkg::H_IDLE: if (start) begin
          txbits_reg <= {1'b0, pwdata[2:0], 3'h0};
          total_reg  <= {1'b0, pwdata[2:0], 3'h0} +
                        {3'h0, pwdata[`SEWC_CMD_RX_BIT], 3'h0};
          tx_sh_reg  <= {txa_reg, txb_reg};
          si_reg     <= txa_reg[31];
          cs_n_reg   <= 1'b0;
          bit_reg    <= 7'h00;
          cnt_reg    <= HALF;
          st_reg     <= sewc_pkg::H_LEAD;
        end
        sewc_pkg::H_LEAD, sewc_pkg::H_HIGH: if (cnt_reg == 8'h00) begin
          sck_reg <= 1'b0;
          cnt_reg <= HALF;
          st_reg  <= sewc_pkg::H_LOW;
          if (bit_reg >= txbits_reg)
            rxd_reg <= {rxd_reg[6:0], miso_f_reg};
        end
        sewc_pkg::H_LOW: if (cnt_reg == 8'h00) begin
          cnt_reg <= HALF;
          if (bit_reg == total_reg - 7'h01) begin
            cs_n_reg <= 1'b1;                                // [RULE11]
            st_reg   <= sewc_pkg::H_TAIL;
          end else begin
            sck_reg   <= 1'b1;
            si_reg    <= tx_sh_reg[62];                      // [RULE10]
            tx_sh_reg <= {tx_sh_reg[62:0], 1'b0};
            bit_reg   <= bit_reg + 7'h01;
            st_reg    <= sewc_pkg::H_HIGH;
          end
        end
        sewc_pkg::H_TAIL: if (cnt_reg == 8'h00) begin
          sck_reg <= 1'b1;
          st_reg  <= sewc_pkg::H_IDLE;
        end
      endcase
    end
  end

  assign prdata    = prdata_reg;
  assign pready    = pready_reg;
  assign pslverr   = pslverr_reg;
  assign link.cs_n = cs_n_reg;
  assign link.sck  = sck_reg;
  assign link.si   = si_reg;
  assign link.wp_n = ctrl_reg[0];

endmodule : sewc_master

// [include/sewc_defs.svh]
`ifndef SEWC_DEFS_SVH
`define SEWC_DEFS_SVH
// What this block does
// [RULE1] status byte: protect level, enable latch, busy
// [RULE2] enable latch read-only, 1 means writes permitted
// [RULE3] busy flag read-only, 1 while programming
// [RULE4] during programming only busy bit is valid
// [RULE5] status read: opcode in, status out MSB first
// [RULE6] latch clear at power-up; enable before writes
// [RULE7] clear-enable command blocks writes until re-enabled
// [RULE8] array write needs protect pin, latch, unprotected address
// [RULE9] protect levels: none, 180-1FF, 100-1FF, all
// [RULE10] write: opcode, low address, data, MSB first
// [RULE11] programming starts when select rises after last bit
// [RULE12] while busy only status read is accepted
// [RULE13] page write: four bytes, low two bits wrap
// [RULE14] finished programming clears the enable latch
// [RULE15] write without latch discarded at deselect
// [RULE16] status write changes only the two protect bits
// [RULE17] eight-bit opcodes, bit 3 carries address bit 8
// [RULE18] sample on falling, drive after rising, MSB first
// [RULE19] protect pin low inhibits writes not yet begun
// [RULE20] busy lasts fixed cycles then clears with latch

`define SEWC_OP_SET_WE     8'h06
`define SEWC_OP_CLR_WE     8'h04
`define SEWC_OP_RD_STAT    8'h05
`define SEWC_OP_WR_STAT    8'h01
`define SEWC_OP_ARR_MASK   8'hF7
`define SEWC_OP_ARR_RD     8'h03
`define SEWC_OP_ARR_WR     8'h02
`define SEWC_OP_ADDR_BIT   3

`define SEWC_PROT_L1_BASE  9'h180
`define SEWC_PROT_L2_BASE  9'h100
`define SEWC_BP_RESET      2'h0
`define SEWC_PROG_CYCLES   8'hC8

`define SEWC_CLK_NS        40
`define SEWC_SCK_PERIOD_NS 800
`define SEWC_SCK_HALF_CYC  (`SEWC_SCK_PERIOD_NS / (2 * `SEWC_CLK_NS))

`define SEWC_REG_CMD       8'h00
`define SEWC_REG_TXA       8'h04
`define SEWC_REG_TXB       8'h08
`define SEWC_REG_RXD       8'h0C
`define SEWC_REG_STAT      8'h10
`define SEWC_REG_CTRL      8'h14
`define SEWC_CMD_RX_BIT    3
`define SEWC_STAT_DONE_BIT 1
`define SEWC_CTRL_RESET    32'h0000_0001
`endif

// [include/sewc_link_if.sv]
interface sewc_link_if;
  logic cs_n;
  logic sck;
  logic si;
  logic so;
  logic so_oe;
  logic wp_n;
  logic miso;

  // released data line floats high through the board pull-up
  assign miso = so_oe ? so : 1'b1;

  modport dev (input cs_n, input sck, input si, input wp_n,
               output so, output so_oe);
  modport ctl (output cs_n, output sck, output si, output wp_n,
               input miso);
endinterface : sewc_link_if

// [include/sewc_pkg.sv]
package sewc_pkg;
  typedef enum logic [3:0] {
    D_OPC, D_ADDR, D_DATA, D_WST, D_WST_DONE,
    D_RADDR, D_RDOUT, D_STOUT, D_SKIP
  } sewc_dev_st_t;

  typedef enum logic [2:0] {
    H_IDLE, H_LEAD, H_LOW, H_HIGH, H_TAIL
  } sewc_host_st_t;
endpackage : sewc_pkg

// [test/sewc_link_chk.sv]
`include "sewc_defs.svh"

module sewc_link_chk (
  input wire logic       clk_sys,       // system clock
  input wire logic       rst,           // async reset
  input wire logic       cs_n,          // select, active low
  input wire logic       sck,           // serial clock
  input wire logic       si,            // data to device
  input wire logic       so,            // data from device
  input wire logic       so_oe,         // device drives so
  input wire logic       wp_n,          // write protect, active low
  input wire logic       prog_busy,     // programming running
  input wire logic [1:0] block_protect  // protect level
);
  logic [8:0] busy_cnt;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // counts the high cycles of the busy flag; a counter avoids a long repeat
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      busy_cnt <= 9'h000;
    end else if (prog_busy) begin
      busy_cnt <= busy_cnt + 9'h001;
    end else begin
      busy_cnt <= 9'h000;
    end
  end

  sequence s_sck_park;
    !sck ##[1:12] sck;
  endsequence

  sequence s_launch;
    $rose(prog_busy) ##0 cs_n;
  endsequence

  a_frame_end: assert property ($rose(cs_n) |-> s_sck_park)
    else $error("select rose outside the clock low time");
  a_oe_in_frame: assert property ($rose(so_oe) |-> !cs_n)
    else $error("data out driven while not selected");
  a_oe_release: assert property ($rose(cs_n) |-> ##[1:6] !so_oe)
    else $error("data out not released after deselect");
  a_si_at_fall: assert property ($fell(sck) |-> $stable(si))
    else $error("data in moved at the sampling edge");
  a_so_on_high: assert property (
    so_oe && $past(so_oe) && $changed(so) |-> sck)
    else $error("data out changed outside the clock high time");
  a_busy_launch: assert property (
    s_launch |-> wp_n && !$past(cs_n, 8))
    else $error("programming began without a frame or while protected");
  a_bp_in_cycle: assert property (
    $changed(block_protect) |-> prog_busy || $past(prog_busy))
    else $error("protect level changed outside programming");
  a_busy_count: assert property (
    $fell(prog_busy) |-> busy_cnt == {1'b0, `SEWC_PROG_CYCLES})
    else $error("programming time wrong");
endmodule : sewc_link_chk

// [test/spi_eeprom_status_write_ctrl_tb.sv]
`include "sewc_defs.svh"

module spi_eeprom_status_write_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [31:0] v; logic [31:0] m; logic e;} sewc_note_t;
  logic        clk_sys, rst, psel, penable, pwrite, pready, pslverr, prog_busy;
  logic [7:0]  paddr, d;
  logic [31:0] pwdata, prdata, r, seed;
  logic [1:0]  block_protect;
  logic [63:0] sh;
  logic [7:0]  mem [512];
  logic [7:0]  pg [5];
  logic [8:0]  adr [4] = '{9'h0FF, 9'h100, 9'h17F, 9'h180};
  logic [15:0] frm_q [$];
  sewc_note_t  note_q [$];
  sewc_note_t  nt;
  logic [15:0] f;
  int          fail_count, cmp_count, nb;

  sewc_link_if link_if ();
  sewc_master sewc_master_inst (.clk_sys(clk_sys), .rst(rst), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link_if));
  sewc_eeprom sewc_eeprom_inst (.clk_sys(clk_sys), .rst(rst), .link(link_if),
    .prog_busy(prog_busy), .block_protect(block_protect));
  sewc_link_chk sewc_link_chk_inst (.clk_sys(clk_sys), .rst(rst),
    .cs_n(link_if.cs_n), .sck(link_if.sck), .si(link_if.si), .so(link_if.so),
    .so_oe(link_if.so_oe), .wp_n(link_if.wp_n), .prog_busy(prog_busy),
    .block_protect(block_protect));

  always #20 clk_sys = ~clk_sys;

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  task hang;
    fail_count++;
    end_of_test();
  endtask : hang

  task apb(input logic [7:0] a, input logic w, input logic [31:0] wd,
           output logic [31:0] rd_v);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (pready !== 1'b1) hang();
    rd_v = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] x;
    apb(a, 1'b1, wd, x);
  endtask : wr

  task rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m,
          input logic er, output logic [31:0] x);
    note_q.push_back('{v: {24'h0, e}, m: {24'h0, m}, e: er});
    apb(a, 1'b0, 32'h0, x);
  endtask : rd

  // starts a frame and waits for the sticky done flag
  task cmd(input logic [2:0] len, input logic rx, input logic [31:0] ta,
           input logic [31:0] tb2);
    int n;
    wr(`SEWC_REG_STAT, 32'h0000_0002);
    wr(`SEWC_REG_TXA, ta);
    wr(`SEWC_REG_TXB, tb2);
    frm_q.push_back({ta[31:24], 8'(({5'h0, len} + {7'h0, rx}) * 8)});
    wr(`SEWC_REG_CMD, {28'h0, rx, len});
    n = 0;
    do begin
      rd(`SEWC_REG_STAT, 8'h00, 8'h00, 1'b0, r);
      n++;
    end while (r[1] !== 1'b1 && n < 1000);
    if (r[1] !== 1'b1) hang();
  endtask : cmd

  task op(input logic [7:0] o);
    cmd(3'd1, 1'b0, {o, 24'h0}, 32'h0);
  endtask : op

  task stat(input logic [7:0] e, input logic [7:0] m);
    op_rd_stat();
    rd(`SEWC_REG_RXD, e, m, 1'b0, r);
  endtask : stat

  task op_rd_stat;
    cmd(3'd1, 1'b1, {`SEWC_OP_RD_STAT, 24'h0}, 32'h0);
  endtask : op_rd_stat

  task wait_ready;
    int n;
    n = 0;
    do begin
      op_rd_stat();
      rd(`SEWC_REG_RXD, 8'h00, 8'h00, 1'b0, r);
      n++;
    end while (r[0] !== 1'b0 && n < 20);
    if (r[0] !== 1'b0) hang();
    chk("busy pin", {31'h0, prog_busy}, 32'h0);
  endtask : wait_ready

  function automatic logic [7:0] opa(input logic [7:0] o, input logic [8:0] a);
    return o | {4'h0, a[8], 3'h0};
  endfunction : opa

  task wr_arr(input logic [8:0] a, input logic [7:0] v);
    cmd(3'd3, 1'b0, {opa(`SEWC_OP_ARR_WR, a), a[7:0], v, 8'h0}, 32'h0);
  endtask : wr_arr

  task rd_arr(input logic [8:0] a, input logic [7:0] e);
    cmd(3'd2, 1'b1, {opa(`SEWC_OP_ARR_RD, a), a[7:0], 16'h0}, 32'h0);
    rd(`SEWC_REG_RXD, e, 8'hFF, 1'b0, r);
  endtask : rd_arr

  task cmd_write_status(input logic [7:0] v);
    cmd(3'd2, 1'b0, {`SEWC_OP_WR_STAT, v, 16'h0}, 32'h0);
  endtask : cmd_write_status

  always @(posedge clk_sys) begin
    if (psel && penable && pready && !pwrite) begin
      nt = note_q.pop_front();
      if (nt.m != 32'h0)
        chk("read data", prdata & nt.m, nt.v & nt.m);
      chk("slave error", {31'h0, pslverr}, {31'h0, nt.e});
    end
  end

  always @(negedge link_if.sck) begin
    if (link_if.cs_n === 1'b0) begin
      sh = {sh[62:0], link_if.si};
      nb++;
    end
  end

  always @(posedge link_if.cs_n) begin
    if (nb != 0) begin
      f = frm_q.pop_front();
      chk("frame opcode", 32'((sh >> (nb - 8)) & 64'hFF),
          {24'h0, f[15:8]});
      chk("frame bits", 32'(nb), {24'h0, f[7:0]});
      nb = 0;
    end
  end

  initial begin
    clk_sys = 1'b0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    nb = 0;
    seed = $urandom(32'hD2005988);
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    stat(8'h00, 8'h0F);
    op(`SEWC_OP_SET_WE);
    stat(8'h02, 8'h0F);
    op(`SEWC_OP_CLR_WE);
    stat(8'h00, 8'h02);
    rd(8'h18, 8'h00, 8'hFF, 1'b1, r);
    d = 8'($urandom);
    op(`SEWC_OP_SET_WE);
    wr_arr(9'h055, d);
    chk("busy pin", {31'h0, prog_busy}, 32'h1);
    stat(8'h01, 8'h01);
    wait_ready();
    stat(8'h00, 8'h03);
    wr_arr(9'h055, ~d);
    stat(8'h00, 8'h01);
    rd_arr(9'h055, d);
    op(`SEWC_OP_SET_WE);
    wr_arr(9'h056, d);
    // status write lands while busy and must be dropped
    cmd_write_status(8'h0C);
    wait_ready();
    stat(8'h00, 8'h0C);
    for (int bp = 0; bp < 4; bp++) begin
      op(`SEWC_OP_SET_WE);
      cmd_write_status({4'hF, 2'(bp), 2'h3});
      wait_ready();
      stat({4'h0, 2'(bp), 2'h0}, 8'h0F);
      chk("protect level", {30'h0, block_protect}, 32'(bp));
      foreach (adr[i]) begin
        d = 8'($urandom);
        op(`SEWC_OP_SET_WE);
        wr_arr(adr[i], d);
        wait_ready();
        if (!(bp == 3 || (bp == 2 && adr[i] >= 9'h100) ||
              (bp == 1 && adr[i] >= 9'h180))) mem[adr[i]] = d;
        rd_arr(adr[i], mem[adr[i]]);
      end
    end
    op(`SEWC_OP_SET_WE);
    cmd_write_status(8'h00);
    wait_ready();
    wr(`SEWC_REG_CTRL, 32'h0);
    op(`SEWC_OP_SET_WE);
    wr_arr(9'h0FF, ~mem[9'h0FF]);
    wait_ready();
    rd_arr(9'h0FF, mem[9'h0FF]);
    wr(`SEWC_REG_CTRL, `SEWC_CTRL_RESET);
    foreach (pg[i]) pg[i] = 8'($urandom);
    op(`SEWC_OP_SET_WE);
    cmd(3'd7, 1'b0, {opa(`SEWC_OP_ARR_WR, 9'h1FE), 8'hFE, pg[0], pg[1]},
        {pg[2], pg[3], pg[4], 8'h00});
    wait_ready();
    rd_arr(9'h1FC, pg[2]);
    rd_arr(9'h1FD, pg[3]);
    rd_arr(9'h1FE, pg[4]);
    rd_arr(9'h1FF, pg[1]);
    end_of_test();
  end
endmodule : spi_eeprom_status_write_ctrl_tb
